// File: hw/wdct_top.sv
// Functional notes
// - timeout in interrupt operation sets the flag, bit 7 of control
// - executing the watchdog vector clears the flag
// - writing one to the flag clears it, zero leaves it
// - interrupt requested only when flag, enable and global enable all set
// - reset enable clear, interrupt enable set: interrupt each timeout, no reset
// - both enables set: first timeout only sets the flag
// - combined mode: vector clears enable and flag, leaving reset mode
// - combined mode: second timeout before vector gives system reset
// - fuse clear: 00 stop, 01 interrupt, 10 reset, 11 both
// - fuse programmed: every timeout resets, whatever the enables
// - clearing reset enable or changing prescaler needs change enable set
// - change enable clears itself four clocks after being written one
// - reset enable reads set while watchdog reset flag is set
// - prescaler select is bit 5 then bits 2 to 0
// - timeout 2048 oscillator cycles at code 0, doubling to code 1001
// - counter advances on the separate 128 kHz oscillator
// - fuse programmed holds reset enable at 1, interrupt enable 0
// - restart instruction zeroes counter; software restarts before timeout
`timescale 1ns/1ps
`default_nettype none

module wdct_top #(
  parameter logic [wdct_pkg::WDCT_CNT_W-1:0] BASE_TIMEOUT_CYCLES =
    wdct_pkg::WDCT_BASE_TIMEOUT
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // watchdog oscillator
  input  wire logic        osc_in,
  // processor core
  input  wire logic        always_on_fuse,
  input  wire logic        watchdog_reset_flag,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_ack,
  input  wire logic        counter_restart,
  output logic             timeout_irq,
  output logic             system_reset
);
  import wdct_pkg::*;

  typedef struct packed {
    logic        flag;
    logic        ie;
    logic [3:0]  ps;
    logic        ce;
    logic [2:0]  ce_cnt;
    logic        re;
    logic        wr_ctrl;
    logic        sys_reset;
    logic [31:0] rdata;
  } wdct_state_s;

  wdct_state_s st_reg;
  wdct_state_s st_next;

  logic       tmo;
  logic       run;
  logic       fuse_prog;
  logic       re_eff;
  wdct_mode_e mode;

  // fuse reads 0 when programmed
  assign fuse_prog = !always_on_fuse;
  assign re_eff    = st_reg.re || watchdog_reset_flag || fuse_prog;

  always_comb begin
    if (fuse_prog) begin
      mode = WDCT_MODE_RESET;
    end else begin
      case ({re_eff, st_reg.ie})
        2'b00:   mode = WDCT_MODE_STOPPED;
        2'b01:   mode = WDCT_MODE_IRQ;
        2'b10:   mode = WDCT_MODE_RESET;
        2'b11:   mode = WDCT_MODE_IRQ_RESET;
        default: mode = WDCT_MODE_STOPPED;
      endcase
    end
  end

  assign run = (mode != WDCT_MODE_STOPPED);

  wdct_counter u_counter (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .osc_in          (osc_in),
    .base_timeout    (BASE_TIMEOUT_CYCLES),
    .run             (run),
    .restart         (counter_restart),
    .prescale_select (st_reg.ps),
    .timeout         (tmo)
  );

  always_comb begin
    logic [7:0] wd;
    logic       rd_access;
    logic       wr_access;
    logic       next_re_eff;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;
    wd          = hwdata[7:0];
    rd_access   = 1'b0;
    wr_access   = 1'b0;
    next_re_eff = 1'b0;
    ctrl_view   = 8'h00;
    stat_view   = 8'h00;
    st_next           = st_reg;
    st_next.sys_reset = 1'b0;
    st_next.wr_ctrl   = 1'b0;
    st_next.rdata     = 32'h0000_0000;

    // protected window closes by itself
    if (st_reg.ce) begin
      if (st_reg.ce_cnt == WDCT_CE_WINDOW_CYCLES - 3'h1) begin
        st_next.ce     = 1'b0;
        st_next.ce_cnt = 3'h0;
      end else begin
        st_next.ce_cnt = st_reg.ce_cnt + 3'h1;
      end
    end

    // core executes the watchdog vector
    if (irq_vector_ack) begin
      st_next.flag = 1'b0;
      if (mode == WDCT_MODE_IRQ_RESET) begin
        st_next.ie = 1'b0;
      end
    end

    // data phase of a control write
    if (st_reg.wr_ctrl) begin
      if (wd[WDCT_FLAG_BIT]) begin
        st_next.flag = 1'b0;
      end
      st_next.ie = wd[WDCT_IE_BIT];
      if (wd[WDCT_RE_BIT]) begin
        st_next.re = 1'b1;
      end else if (st_reg.ce) begin
        st_next.re = 1'b0;
      end
      if (st_reg.ce) begin
        st_next.ps = {wd[WDCT_PS3_BIT], wd[WDCT_PS_LO_HI:0]};
      end
      if (wd[WDCT_CE_BIT]) begin
        st_next.ce     = 1'b1;
        st_next.ce_cnt = 3'h0;
      end
    end

    // fuse locks the enables, ignoring writes
    if (fuse_prog) begin
      st_next.re = 1'b1;
      st_next.ie = 1'b0;
    end

    // timeout last so a set beats a same-cycle clear
    if (tmo) begin
      case (mode)
        WDCT_MODE_IRQ: begin
          st_next.flag = 1'b1;
        end
        WDCT_MODE_RESET: begin
          st_next.sys_reset = 1'b1;
        end
        WDCT_MODE_IRQ_RESET: begin
          if (st_reg.flag) begin
            st_next.sys_reset = 1'b1;
          end else begin
            st_next.flag = 1'b1;
          end
        end
        WDCT_MODE_STOPPED: begin
          st_next.sys_reset = 1'b0;
        end
        default: begin
          st_next.sys_reset = 1'b0;
        end
      endcase
    end

    // address phase
    rd_access = hsel && htrans[1] && hready && !hwrite;
    wr_access = hsel && htrans[1] && hready && hwrite;
    if (wr_access && (haddr[11:0] == WDCT_CTRL_OFFSET)) begin
      st_next.wr_ctrl = 1'b1;
    end

    // control read data from next state, so a write just ahead is seen; status from current mode and window
    next_re_eff = st_next.re || watchdog_reset_flag || fuse_prog;
    ctrl_view[WDCT_FLAG_BIT]     = st_next.flag;
    ctrl_view[WDCT_IE_BIT]       = st_next.ie;
    ctrl_view[WDCT_PS3_BIT]      = st_next.ps[3];
    ctrl_view[WDCT_CE_BIT]       = st_next.ce;
    ctrl_view[WDCT_RE_BIT]       = next_re_eff;
    ctrl_view[WDCT_PS_LO_HI:0]   = st_next.ps[2:0];
    stat_view[WDCT_STAT_MODE_HI:WDCT_STAT_MODE_LO] = mode;
    stat_view[WDCT_STAT_WIN_BIT]  = st_reg.ce;
    stat_view[WDCT_STAT_FUSE_BIT] = fuse_prog;
    if (rd_access) begin
      case (haddr[11:0])
        WDCT_CTRL_OFFSET: st_next.rdata = {24'h00_0000, ctrl_view};
        WDCT_STAT_OFFSET: st_next.rdata = {24'h00_0000, stat_view};
        default:          st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.flag      <= WDCT_FLAG_RST;
      st_reg.ie        <= WDCT_IE_RST;
      st_reg.ps        <= WDCT_PS_RST;
      st_reg.ce        <= WDCT_CE_RST;
      st_reg.ce_cnt    <= 3'h0;
      st_reg.re        <= WDCT_RE_RST;
      st_reg.wr_ctrl   <= 1'b0;
      st_reg.sys_reset <= 1'b0;
      st_reg.rdata     <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // zero wait states, always okay
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_reg.rdata;
  assign timeout_irq  = st_reg.flag && st_reg.ie && global_irq_enable;
  assign system_reset = st_reg.sys_reset;

endmodule : wdct_top

`default_nettype wire

// File: hw/wdct_pkg.sv
package wdct_pkg;

  // register byte offsets inside the slave's window
  localparam logic [11:0] WDCT_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] WDCT_STAT_OFFSET = 12'h004;

  // watchdog_control_status field positions
  localparam int unsigned WDCT_FLAG_BIT = 7;
  localparam int unsigned WDCT_IE_BIT   = 6;
  localparam int unsigned WDCT_PS3_BIT  = 5;
  localparam int unsigned WDCT_CE_BIT   = 4;
  localparam int unsigned WDCT_RE_BIT   = 3;
  localparam int unsigned WDCT_PS_LO_HI = 2;

  // status register field positions
  localparam int unsigned WDCT_STAT_MODE_LO = 0;
  localparam int unsigned WDCT_STAT_MODE_HI = 1;
  localparam int unsigned WDCT_STAT_WIN_BIT = 2;
  localparam int unsigned WDCT_STAT_FUSE_BIT = 3;

  // reset values
  localparam logic       WDCT_FLAG_RST = 1'b0;
  localparam logic       WDCT_IE_RST   = 1'b0;
  localparam logic       WDCT_CE_RST   = 1'b0;
  localparam logic       WDCT_RE_RST   = 1'b0;
  localparam logic [3:0] WDCT_PS_RST   = 4'h0;

  // change window length in core clock cycles
  localparam logic [2:0] WDCT_CE_WINDOW_CYCLES = 3'h4;

  // timeout in oscillator cycles: base for code 0, doubling up to code 9
  localparam int unsigned WDCT_CNT_W = 21;
  localparam logic [20:0] WDCT_BASE_TIMEOUT = 21'h00_0800;
  localparam logic [3:0]  WDCT_PS_MAX_CODE  = 4'h9;

  typedef enum logic [1:0] {
    WDCT_MODE_STOPPED,
    WDCT_MODE_IRQ,
    WDCT_MODE_RESET,
    WDCT_MODE_IRQ_RESET
  } wdct_mode_e;

endpackage : wdct_pkg

// File: hw/wdct_counter.sv
`timescale 1ns/1ps
`default_nettype none

module wdct_counter (
  // clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // watchdog oscillator pin
  input  wire logic                           osc_in,
  // control
  input  wire logic [wdct_pkg::WDCT_CNT_W-1:0] base_timeout,
  input  wire logic                           run,
  input  wire logic                           restart,
  input  wire logic [3:0]                     prescale_select,
  // event
  output logic                                timeout
);
  import wdct_pkg::*;

  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  s3;
    logic [WDCT_CNT_W-1:0] count;
    logic                  timeout;
  } wdct_cnt_s;

  wdct_cnt_s cnt_reg;
  wdct_cnt_s cnt_next;

  always_comb begin
    logic [3:0]            shift;
    logic [WDCT_CNT_W-1:0] limit;
    logic [WDCT_CNT_W-1:0] inc;
    shift = 4'h0;
    limit = '0;
    inc   = '0;
    cnt_next         = cnt_reg;
    cnt_next.timeout = 1'b0;
    // first stage feeds only the second
    cnt_next.s1 = osc_in;
    cnt_next.s2 = cnt_reg.s1;
    cnt_next.s3 = cnt_reg.s2;
    // reserved codes behave like the longest period
    shift = (prescale_select > WDCT_PS_MAX_CODE) ? WDCT_PS_MAX_CODE
                                                 : prescale_select;
    limit = WDCT_CNT_W'(base_timeout << shift);
    inc   = cnt_reg.count + {{(WDCT_CNT_W-1){1'b0}}, 1'b1};
    if (!run || restart) begin
      cnt_next.count = '0;
    end else if (cnt_reg.s2 && !cnt_reg.s3) begin
      // >= so a shortened period still fires on the next oscillator edge
      if (inc >= limit) begin
        cnt_next.count   = '0;
        cnt_next.timeout = 1'b1;
      end else begin
        cnt_next.count = inc;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign timeout = cnt_reg.timeout;

endmodule : wdct_counter

`default_nettype wire

// File: dv/wdct_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module wdct_core_model (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // bench control
  input  wire logic gie_on,
  // watchdog side
  input  wire logic timeout_irq,
  output logic      global_irq_enable,
  output logic      irq_vector_ack
);
  int unsigned wait_cnt;

  assign global_irq_enable = gie_on;

  // random latency: some vectors prompt, some slow
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_vector_ack <= 1'b0;
      wait_cnt       <= 0;
    end else if (irq_vector_ack || !timeout_irq) begin
      irq_vector_ack <= 1'b0;
      wait_cnt       <= $urandom_range(30, 0);
    end else if (wait_cnt == 0) begin
      irq_vector_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : wdct_core_model

`default_nettype wire

// File: dv/wdct_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module wdct_assertions (
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // core side
  input wire logic        always_on_fuse,
  input wire logic        global_irq_enable,
  input wire logic        irq_vector_ack,
  input wire logic        counter_restart,
  input wire logic        timeout_irq,
  input wire logic        system_reset
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ready_high: assert property (hreadyout)
    else $error("slave stalled");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_idle: assert property (
    !$past(hsel && htrans[1] && !hwrite && hready) |-> ~|hrdata)
    else $error("read data outside data phase");
  a_irq_gated: assert property (timeout_irq |-> global_irq_enable)
    else $error("interrupt without global enable");
  a_ack_clears: assert property (
    irq_vector_ack && !system_reset |=> !timeout_irq [*3])
    else $error("interrupt still pending after vector");
  a_reset_single: assert property (system_reset |=> !system_reset)
    else $error("reset pulse too long");
  a_fuse_no_irq: assert property (!always_on_fuse |-> !timeout_irq)
    else $error("interrupt with fuse programmed");
  a_restart_quiet: assert property (
    counter_restart [*8] |-> !system_reset)
    else $error("reset while counter held");
endmodule : wdct_assertions

bind wdct_top wdct_assertions wdct_assertions_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .always_on_fuse(always_on_fuse),
  .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .counter_restart(counter_restart),
  .timeout_irq(timeout_irq), .system_reset(system_reset));

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int BASE = 4;
  logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, osc;
  logic        fuse, wrf, gie_on, rst_cmd, irq, srst, gie, ack;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        m_fl, m_ie, m_re;
  logic [3:0]  m_ps;
  int          n_fail, total_checks, n_rst, n_osc, cyc, o, nr;

  wdct_top #(.BASE_TIMEOUT_CYCLES(21'(BASE))) wdct_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .osc_in(osc), .always_on_fuse(fuse), .watchdog_reset_flag(wrf),
    .global_irq_enable(gie), .irq_vector_ack(ack),
    .counter_restart(rst_cmd), .timeout_irq(irq), .system_reset(srst));
  wdct_core_model wdct_core_model_i (
    .hclk(hclk), .hresetn(hresetn), .gie_on(gie_on),
    .timeout_irq(irq), .global_irq_enable(gie), .irq_vector_ack(ack));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // 128 kHz, rising edges never on a core clock edge
  initial begin
    osc = 1'b0;
    forever #3906 osc = ~osc;
  end
  always @(posedge osc) n_osc++;
  always @(posedge srst) n_rst++;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      finish_test();
    end
  end

  function automatic logic [7:0] ex();
    return {m_fl, m_ie, m_ps[3], 1'b0, m_re | wrf | ~fuse, m_ps[2:0]};
  endfunction : ex

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // hready and read data taken at the rising edge, before its updates land
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0_0000, a};
    do begin
      @(posedge hclk);
    end while (!hrdy);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do begin
      @(posedge hclk);
      r = hrdata;
    end while (!hrdy);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h00_0000, e});
  endtask : rd

  task automatic win(input logic [7:0] d);
    wr(12'h000, 8'h18);
    wr(12'h000, d);
  endtask : win

  task automatic kick();
    rst_cmd <= 1'b1;
    @(posedge hclk);
    rst_cmd <= 1'b0;
  endtask : kick

  task automatic osc_wait(input int n);
    o = n_osc;
    wait (n_osc >= o + n);
    repeat (8) @(posedge hclk);
  endtask : osc_wait

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {wrf, gie_on, rst_cmd, m_fl, m_ie, m_re, m_ps} = '0;
    fuse = 1'b1;
    void'($urandom(62));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h000, ex());
    wr(12'h008, 8'($urandom));
    rd(12'h008, 8'h00);
    wr(12'h000, 8'h29);
    m_re = 1'b1;
    rd(12'h000, ex());
    for (int k = 5; k >= 2; k -= 3) begin
      wr(12'h000, 8'h18);
      repeat (k) @(posedge hclk);
      wr(12'h000, 8'h21);
      if (k == 2) {m_re, m_ps} = 5'h09;
      repeat (4) @(posedge hclk);
      rd(12'h000, ex());
    end
    wrf <= 1'b1;
    @(posedge hclk);
    rd(12'h000, ex());
    wrf <= 1'b0;
    @(posedge hclk);
    rd(12'h000, ex());
    for (int i = 0; i < 4; i++) begin
      win({1'b0, i[0], 2'h0, i[1], 3'h0});
      {m_re, m_ie, m_ps} = {i[1], i[0], 4'h0};
      repeat (4) @(posedge hclk);
      rd(12'h004, 8'(i));
    end
    kick();
    osc_wait(BASE + 1);
    m_fl = 1'b1;
    rd(12'h000, ex());
    chk(n_rst, 0);
    @(posedge srst);
    @(posedge hclk);
    chk(n_rst, 1);
    gie_on <= 1'b1;
    @(posedge ack);
    repeat (2) @(posedge hclk);
    {m_fl, m_ie} = 2'h0;
    rd(12'h000, ex());
    wr(12'h000, 8'h48);
    m_ie = 1'b1;
    rd(12'h000, ex());
    win(8'h40);
    m_re = 1'b0;
    nr = n_rst;
    kick();
    @(posedge ack);
    repeat (2) @(posedge hclk);
    m_fl = 1'b0;
    rd(12'h000, ex());
    gie_on <= 1'b0;
    kick();
    osc_wait(BASE + 1);
    m_fl = 1'b1;
    rd(12'h000, ex());
    chk(irq, 0);
    wr(12'h000, 8'h40);
    rd(12'h000, ex());
    wr(12'h000, 8'hC0);
    m_fl = 1'b0;
    rd(12'h000, ex());
    chk(n_rst, nr);
    for (int p = 1; p >= 0; p--) begin
      win({4'h0, 1'b1, 3'(p)});
      {m_ie, m_re, m_ps} = {2'h1, 4'(p)};
      @(posedge srst);
      o = n_osc;
      @(posedge srst);
      chk(n_osc - o, BASE << p);
      @(posedge hclk);
    end
    // held restart outlasts one full timeout period
    rst_cmd <= 1'b1;
    nr = n_rst;
    repeat (5000) @(posedge hclk);
    rst_cmd <= 1'b0;
    o = n_osc;
    @(posedge srst);
    @(posedge hclk);
    chk(n_rst, nr + 1);
    chk(n_osc - o, BASE);
    @(posedge hclk);
    hresetn <= 1'b0;
    fuse    <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    gie_on  <= 1'b1;
    @(posedge hclk);
    {m_re, m_ie, m_ps} = '0;
    wr(12'h000, 8'h40);
    rd(12'h000, ex());
    rd(12'h004, 8'h0A);
    @(posedge srst);
    @(posedge hclk);
    chk(irq, 0);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
